//--- design/rlk_pkg.sv
// package for the lookup ram access port: offsets, fields, types
package rlk_pkg;
  localparam int RLK_ADDR_W = 7;
  localparam int RLK_DATA_W = 8;
  localparam int RLK_BUS_AW = 16;
  // printed offsets are not multiples of four: index, byte address = 4*index
  localparam logic [15:0] RLK_IDX_ADDR = 16'h2887;
  localparam logic [15:0] RLK_IDX_DATA = 16'h2888;
  localparam logic [15:0] RLK_IDX_STRB = 16'h2889;
  localparam int RLK_AUTOI_BIT = 7;
  localparam int RLK_RD_BIT = 1;
  localparam int RLK_WR_BIT = 0;
  localparam logic [7:0] RLK_RST_ADDR = 8'h00;
  localparam logic [7:0] RLK_RST_DATA = 8'h00;
  // ram access engine spends this many cycles, busy then done, after the start cycle that sees the strobe
  localparam int RLK_ACC_CYC = 2;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic we;
    logic en;
  } rlk_ram_req_t;

  typedef enum logic [1:0] {
    RLK_IDLE,
    RLK_BUSY,
    RLK_DONE
  } rlk_state_t;
endpackage

//--- design/rlk_port.sv
// lookup ram access port: wishbone registers plus the lookup ram itself
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module rlk_port
  import rlk_pkg::*;
#(
  parameter int DEPTH = 128
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [17:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // status
  output logic busy
);
  logic [6:0] addr_r;
  logic autoi_r;
  logic [7:0] data_r;
  logic rd_r, wr_r;
  logic [31:0] dat_r;
  logic ack_r;
  rlk_state_t st_r;
  logic [7:0] ram [DEPTH];
  logic [7:0] rdata_r;
  rlk_ram_req_t req;

  // word index decode, used for reads and writes
  function automatic logic hit(input logic [17:0] a, input logic [15:0] idx);
    return (a[17:2] == idx) && (a[1:0] == 2'b00);
  endfunction

  // a request is taken once: ack_r masks it in the cycle it is answered,
  // so a master that holds cyc and stb until it sees ack is not taken twice
  logic acc, wr_en;
  assign acc = cyc_i && stb_i && !ack_r;
  assign wr_en = acc && we_i && sel_i[0];
  logic start, done;
  assign start = (st_r == RLK_IDLE) && (rd_r || wr_r);
  assign done = (st_r == RLK_DONE);

  // ram request presented while the engine is busy
  always_comb begin
    req.addr = addr_r;
    req.wdata = data_r;
    req.we = wr_r && (st_r == RLK_BUSY);
    req.en = (st_r == RLK_BUSY);
  end

  // the lookup ram; registered read port
  always_ff @(posedge clk) begin
    if (req.en && req.we) begin
      ram[req.addr] <= req.wdata;
    end
    rdata_r <= ram[req.addr];
  end

  // access engine: one busy cycle, one done cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= RLK_IDLE;
    end else begin
      unique case (st_r)
        RLK_IDLE: if (start) st_r <= RLK_BUSY;
        RLK_BUSY: st_r <= RLK_DONE;
        RLK_DONE: st_r <= RLK_IDLE;
        default: st_r <= RLK_IDLE; // unused code, recover to idle
      endcase
    end
  end

  // address register; completion increment beats a software write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_r <= RLK_RST_ADDR[6:0];
      autoi_r <= RLK_RST_ADDR[7];
    end else if (done) begin
      if (autoi_r) begin
        addr_r <= addr_r + 7'h01;
      end
    end else if (wr_en && hit(adr_i, RLK_IDX_ADDR)) begin
      addr_r <= dat_i[6:0];
      autoi_r <= dat_i[RLK_AUTOI_BIT];
    end
  end

  // data register; read completion loads ram byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_r <= RLK_RST_DATA;
    end else if (done && rd_r) begin
      data_r <= rdata_r;
    end else if (wr_en && hit(adr_i, RLK_IDX_DATA)) begin
      data_r <= dat_i[7:0];
    end
  end

  // strobes: software sets only while the engine is idle, hardware clears on completion;
  // a set in a busy or done cycle is dropped and must be written again
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else if (done) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else if (wr_en && hit(adr_i, RLK_IDX_STRB) && st_r == RLK_IDLE) begin
      rd_r <= rd_r | dat_i[RLK_RD_BIT];
      wr_r <= wr_r | dat_i[RLK_WR_BIT];
    end
  end

  // bus answer: one-cycle ack, unmapped reads return zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= acc;
      dat_r <= 32'h0000_0000;
      if (acc && !we_i) begin
        if (hit(adr_i, RLK_IDX_ADDR)) dat_r <= {24'h0, autoi_r, addr_r};
        else if (hit(adr_i, RLK_IDX_DATA)) dat_r <= {24'h0, data_r};
        else if (hit(adr_i, RLK_IDX_STRB)) dat_r <= {30'h0, rd_r, wr_r};
      end
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign busy = rd_r || wr_r;

  // checker sequences: a strobe lives through a start, a busy and a done
  // cycle, so it is sampled high three times before it reads low
  sequence s_start;
    st_r == RLK_IDLE && (rd_r || wr_r);
  endsequence
  sequence s_held;
    (rd_r || wr_r) [*3];
  endsequence
  sequence s_clear;
    !(rd_r || wr_r);
  endsequence
  // a bus request taken at this edge
  sequence s_take;
    acc;
  endsequence

  // strobe lifetime: held until completion, cleared right after it
  a_strobe_clears: assert property (
    @(posedge clk) disable iff (rst)
    s_start |-> s_held ##1 s_clear)
    else $error("strobe did not clear after access");
  a_read_holds: assert property (
    @(posedge clk) disable iff (rst)
    rd_r && !done |=> rd_r)
    else $error("read strobe cleared before completion");
  a_write_holds: assert property (
    @(posedge clk) disable iff (rst)
    wr_r && !done |=> wr_r)
    else $error("write strobe cleared before completion");
  // no strobe, no access: the engine only leaves idle on request
  a_engine_idle: assert property (
    @(posedge clk) disable iff (rst)
    st_r == RLK_IDLE && !(rd_r || wr_r) |=> st_r == RLK_IDLE)
    else $error("access started without a strobe");

  // address stepping at completion; the flag itself is not touched at completion
  a_autoinc_step: assert property (
    @(posedge clk) disable iff (rst)
    done && autoi_r |=> addr_r == $past(addr_r) + 7'h01)
    else $error("address did not increment");
  a_noinc_hold: assert property (
    @(posedge clk) disable iff (rst)
    done && !autoi_r |=> addr_r == $past(addr_r))
    else $error("address moved without auto-increment");
  a_autoi_kept: assert property (
    @(posedge clk) disable iff (rst)
    done |=> autoi_r == $past(autoi_r))
    else $error("auto-increment flag changed at completion");
  // a software write loads both the address field and the flag
  a_addr_load: assert property (
    @(posedge clk) disable iff (rst)
    wr_en && hit(adr_i, RLK_IDX_ADDR) && !done
    |=> {autoi_r, addr_r} == $past(dat_i[7:0]))
    else $error("address register write lost");

  // data movement between the data register and the ram
  a_read_data: assert property (
    @(posedge clk) disable iff (rst)
    done && rd_r |=> data_r == $past(rdata_r) && !rd_r)
    else $error("read data not loaded with strobe clear");
  a_write_ram: assert property (
    @(posedge clk) disable iff (rst)
    req.en && req.we |=> ram[$past(addr_r)] == $past(data_r))
    else $error("ram write missing");

  // register readback; the answer stands one cycle, with ack
  a_addr_read: assert property (
    @(posedge clk) disable iff (rst)
    acc && !we_i && hit(adr_i, RLK_IDX_ADDR) && !done
    |=> dat_o[7:0] == {$past(autoi_r), $past(addr_r)})
    else $error("address register readback wrong");
  a_data_read: assert property (
    @(posedge clk) disable iff (rst)
    acc && !we_i && hit(adr_i, RLK_IDX_DATA)
    |=> dat_o[7:0] == $past(data_r))
    else $error("data register readback wrong");
  a_strobe_read: assert property (
    @(posedge clk) disable iff (rst)
    acc && !we_i && hit(adr_i, RLK_IDX_STRB)
    |=> dat_o[1:0] == {$past(rd_r), $past(wr_r)})
    else $error("strobe register readback wrong");

  // bus handshake: every taken request gets a one-cycle ack
  a_ack_follows: assert property (
    @(posedge clk) disable iff (rst)
    s_take |=> ack_o)
    else $error("taken request not acknowledged");
  a_ack_pulse: assert property (
    @(posedge clk) disable iff (rst)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
endmodule
`default_nettype wire

//--- verif/tb_rtc_lookup_ram_access_port.sv
// self-checking bench for the lookup ram access port
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_lookup_ram_access_port;
  import rlk_pkg::*;
  // start near the top so auto-increment wraps past 127
  localparam logic [6:0] A = 7'h7E;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [17:0] adr = 18'h0;
  logic [3:0] sel = 4'h1;
  logic [31:0] dat = 32'h0, rd, seed = 32'hF7C9;
  logic ack, busy;
  logic [31:0] exp_q[$];
  logic [7:0] mem[4];
  int fails = 0, checks_done = 0;
  rlk_port dut (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rd), .ack_o(ack),
    .busy(busy));
  always #10 clk = ~clk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  // one classic cycle; only the watchdog ends a wait for a lost ack
  task automatic bus(input logic w, input logic [15:0] i, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    dat <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    // the slave must drop ack in the cycle after it gave it
    @(posedge clk);
    chk("ack drop", 0, ack);
  endtask
  task automatic rdx(input logic [15:0] i, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, i, 8'h00);
  endtask
  task automatic settle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("busy clears", 0, busy);
  endtask
  // each read ack takes the oldest note off the queue
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0)
        chk("spurious ack", 1, 0);
      else
        chk("read data", exp_q.pop_front(), rd);
    end
  end
  task automatic complete_run;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // tests need under 150 cycles; 4000 cycles means a hang
  initial begin
    #80000;
    fails++;
    complete_run;
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdx(RLK_IDX_ADDR, 8'h00);
    rdx(RLK_IDX_DATA, 8'h00);
    rdx(RLK_IDX_STRB, 8'h00);
    bus(1'b1, 16'h2886, 8'hA5);
    rdx(16'h2886, 8'h00);
    $display("test reset and unmapped done");
    bus(1'b1, RLK_IDX_ADDR, {1'b1, A});
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      mem[i] = seed[7:0];
      bus(1'b1, RLK_IDX_DATA, mem[i]);
      bus(1'b1, RLK_IDX_STRB, 8'h01);
      @(negedge clk);
      chk("busy", 1, busy);
      settle;
    end
    rdx(RLK_IDX_ADDR, {1'b1, 7'(A + 7'd4)});
    rdx(RLK_IDX_STRB, 8'h00);
    $display("test write burst done");
    bus(1'b1, RLK_IDX_ADDR, {1'b0, A});
    bus(1'b1, RLK_IDX_STRB, 8'h02);
    settle;
    rdx(RLK_IDX_ADDR, {1'b0, A});
    rdx(RLK_IDX_DATA, mem[0]);
    bus(1'b1, RLK_IDX_ADDR, {1'b1, A});
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, RLK_IDX_STRB, 8'h02);
      settle;
      rdx(RLK_IDX_DATA, mem[i]);
    end
    $display("test read burst done");
    @(posedge clk);
    complete_run;
  end
endmodule
`default_nettype wire
